// ==== pin_volume_digitizer_control.sv ====
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module pin_volume_digitizer_control
   import pin_volume_pkg::*;
#(
   parameter int BASE_DIV = TPUT0_DIV
)
(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        mclk_in,
   input  wire logic        rc_osc_in,
   input  wire logic        volume_detect_above,
   input  wire logic [6:0]  reg_gain_code,
   output logic             sar_power_en,
   output logic [6:0]       sar_trial_code,
   output logic [6:0]       play_gain_code,
   output logic             gain_from_pin
);

   // ==========================================================
   // register state
   // ==========================================================
   logic [7:0]  page_ff;
   vol_cfg_t    cfg_ff;
   logic        gain_rsv_ff;
   logic [6:0]  applied_ff;
   logic        wait_ff;
   logic [31:0] rdata_ff;
   logic        req;
   logic        on_page0;
   logic [7:0]  rd_byte;

   assign req      = avs_read | avs_write;
   assign on_page0 = (page_ff == 8'h00);

   always_comb
   begin
      rd_byte = 8'h00;
      if (avs_address == PAGE_SELECT_IDX)
      begin
         rd_byte = page_ff;                                   // [R7]
      end
      else if (on_page0 && avs_address == VOL_DIG_CONFIG_IDX)
      begin
         rd_byte = cfg_ff;
      end
      else if (on_page0 && avs_address == PIN_GAIN_READ_IDX)
      begin
         rd_byte = {gain_rsv_ff, applied_ff};                 // [R6]
      end
   end

   // ==========================================================
   // avalon slave: one wait cycle, then the access completes
   // ==========================================================
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         if (req && wait_ff)
         begin
            wait_ff  <= 1'b0;
            rdata_ff <= {24'h00_0000, rd_byte};
         end
         else
         begin
            wait_ff <= 1'b1;
         end
      end
   end

   assign avs_waitrequest = wait_ff;
   assign avs_readdata    = rdata_ff;

   logic wr_now;
   assign wr_now = avs_write && !wait_ff && avs_byteenable[0];

   // page number lives at address 0 of every page
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         page_ff <= PAGE_SELECT_RST;
      end
      else if (clk_en && wr_now && avs_address == PAGE_SELECT_IDX)
      begin
         page_ff <= avs_writedata[7:0];                       // [R7]
      end
   end

   // reserved ranges take no write; they read as zero
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_ff      <= vol_cfg_t'(VOL_DIG_CONFIG_RST);
         gain_rsv_ff <= 1'b0;
      end
      else if (clk_en && wr_now && on_page0)
      begin
         if (avs_address == VOL_DIG_CONFIG_IDX)
         begin
            cfg_ff <= vol_cfg_t'(avs_writedata[7:0]);         // [R9]
         end
         else if (avs_address == PIN_GAIN_READ_IDX)
         begin
            gain_rsv_ff <= avs_writedata[7];                  // [R9]
         end
      end
   end

   // ==========================================================
   // converter clock: edges of the chosen source drive the sar
   // ==========================================================
   logic mclk_d_ff;
   logic osc_d_ff;
   logic src_tick;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mclk_d_ff <= 1'b0;
         osc_d_ff  <= 1'b0;
      end
      else if (clk_en)
      begin
         mclk_d_ff <= mclk_in;
         osc_d_ff  <= rc_osc_in;
      end
   end

   // counting source edges, not ref_clk cycles, makes the rate scale with the oscillator
   assign src_tick = cfg_ff.clk_mclk ? (mclk_in & ~mclk_d_ff)
                                     : (rc_osc_in & ~osc_d_ff);  // [R2] [R5]

   // ==========================================================
   // throughput divider
   // ==========================================================
   logic [31:0] period;
   logic [31:0] div_ff;
   logic        conv_start;

   assign period     = 32'(BASE_DIV) >> cfg_ff.tput;          // [R4]
   assign conv_start = src_tick && (div_ff >= period - 32'd1);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_ff <= 32'h0000_0000;
      end
      else if (clk_en)
      begin
         if (!cfg_ff.pin_ctl)
         begin
            div_ff <= 32'h0000_0000;                          // [R1]
         end
         else if (conv_start)
         begin
            div_ff <= 32'h0000_0000;
         end
         else if (src_tick)
         begin
            div_ff <= div_ff + 32'd1;
         end
      end
   end

   // ==========================================================
   // successive approximation, one bit per source edge
   // ==========================================================
   sar_state_t  state_ff;
   logic [6:0]  trial_ff;
   logic [2:0]  bit_ff;
   logic [6:0]  kept;
   logic [6:0]  result;
   logic        conv_done;

   assign kept      = volume_detect_above ? trial_ff
                                          : (trial_ff & ~(7'h01 << bit_ff));
   assign result    = (kept == GAIN_CODE_RESERVED) ? GAIN_CODE_MAX : kept;  // [R6]
   assign conv_done = (state_ff == SAR_TRIAL) && src_tick && (bit_ff == 3'd0);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= SAR_OFF;
         trial_ff <= 7'h00;
         bit_ff   <= 3'd0;
      end
      else if (clk_en)
      begin
         if (!cfg_ff.pin_ctl)
         begin
            state_ff <= SAR_OFF;                              // [R1]
            trial_ff <= 7'h00;
         end
         else
         begin
            case (state_ff)
               SAR_OFF:
               begin
                  state_ff <= SAR_WAIT;
               end
               SAR_WAIT:
               begin
                  if (conv_start)
                  begin
                     state_ff <= SAR_TRIAL;
                     trial_ff <= SAR_FIRST_TRIAL;
                     bit_ff   <= 3'(SAR_MSB);
                  end
               end
               SAR_TRIAL:
               begin
                  if (src_tick)
                  begin
                     if (bit_ff == 3'd0)
                     begin
                        state_ff <= SAR_WAIT;
                        trial_ff <= kept;
                     end
                     else
                     begin
                        trial_ff <= kept | (7'h01 << (bit_ff - 3'd1));
                        bit_ff   <= bit_ff - 3'd1;
                     end
                  end
               end
               default:
               begin
                  state_ff <= SAR_OFF;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // hysteresis and applied gain
   // ==========================================================
   logic [6:0] delta;
   logic [1:0] hyst_lim;

   assign delta    = (result > applied_ff) ? (result - applied_ff) : (applied_ff - result);
   // a stray 11 behaves as the widest setting rather than something undefined
   assign hyst_lim = (cfg_ff.hyst > 2'h2) ? 2'h2 : cfg_ff.hyst;    // [R3]

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         applied_ff <= PIN_GAIN_RST;
      end
      else if (clk_en && conv_done && (delta > {5'h00, hyst_lim}))
      begin
         applied_ff <= result;                                // [R3] [R10]
      end
   end

   // ==========================================================
   // outputs to the playback path and the analog converter
   // ==========================================================
   logic       pwr_ff;
   logic [6:0] play_ff;
   logic       from_pin_ff;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pwr_ff      <= 1'b0;
         play_ff     <= 7'h00;
         from_pin_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         pwr_ff      <= cfg_ff.pin_ctl;                       // [R1]
         from_pin_ff <= cfg_ff.pin_ctl;
         play_ff     <= cfg_ff.pin_ctl ? applied_ff : reg_gain_code;  // [R1] [R10]
      end
   end

   assign sar_power_en   = pwr_ff;
   assign sar_trial_code = trial_ff;
   assign play_gain_code = play_ff;
   assign gain_from_pin  = from_pin_ff;

endmodule : pin_volume_digitizer_control

// ==== pin_volume_pkg.sv ====
// Summary of operation
// [R1] With the control-source bit at 0 playback gain follows the register setting and the digitizer is powered down; at 1 it follows the digitized pin level.
// [R2] The digitizer clock is the internal RC oscillator when its clock-source bit is 0 and the external master clock when it is 1.
// [R3] The two-bit hysteresis field gives no hysteresis at 00, one code at 01 and two codes at 10, and the host never writes 11.
// [R4] The three-bit throughput field sets the conversion rate, 15.625 Hz at code 000 from a 12 MHz master clock, doubling per code up to 2 kHz at 111.
// [R5] With the internal oscillator the rates are those at a nominal 8.2 MHz and scale with the real oscillator frequency.
// [R6] A read-only 7-bit field reports the pin-control gain code, 0 meaning 18 dB, falling by 0.5 dB then 1 dB steps to -63 dB, with code 127 reserved.
// [R7] Address 0 of every page holds the 8-bit page number, reset to 0, which steers all later accesses.
// [R8] The host does not write page 0 addresses 0x50 to 0x73 and 0x76 to 0x7F, whose contents after reset are undefined.
// [R9] The host writes only zero to the upper bit of the gain readback and keeps the reserved configuration bit at its reset value.
// [R10] The gain readback updates once per finished conversion after hysteresis, so it always equals the gain applied; the code applies it only in pin mode.
package pin_volume_pkg;

   // ==========================================================
   // register map (indices; byte address is four times these)
   // ==========================================================
   localparam logic [7:0] PAGE_SELECT_IDX     = 8'h00;
   localparam logic [7:0] VOL_DIG_CONFIG_IDX  = 8'h74;
   localparam logic [7:0] PIN_GAIN_READ_IDX   = 8'h75;
   localparam logic [7:0] RSV_LO_FIRST_IDX    = 8'h50;
   localparam logic [7:0] RSV_LO_LAST_IDX     = 8'h73;
   localparam logic [7:0] RSV_HI_FIRST_IDX    = 8'h76;
   localparam logic [7:0] RSV_HI_LAST_IDX     = 8'h7F;
   localparam logic [7:0] PAGE_SELECT_RST     = 8'h00;
   localparam logic [7:0] VOL_DIG_CONFIG_RST  = 8'h00;
   localparam logic [6:0] PIN_GAIN_RST        = 7'h00;
   localparam logic [6:0] GAIN_CODE_RESERVED  = 7'h7F;
   localparam logic [6:0] GAIN_CODE_MAX       = 7'h7E;

   // ==========================================================
   // hysteresis and conversion timing
   // ==========================================================
   localparam logic [1:0] HYST_NONE           = 2'h0;
   localparam logic [1:0] HYST_ONE            = 2'h1;
   localparam logic [6:0] SAR_FIRST_TRIAL     = 7'h40;
   localparam int         SAR_MSB             = 6;
   localparam longint     REF_MCLK_HZ         = 64'd12_000_000;
   localparam longint     TPUT0_MILLIHZ       = 64'd15_625;
   // source edges per conversion at throughput code 0
   localparam int         TPUT0_DIV           = int'(REF_MCLK_HZ * 64'd1000 / TPUT0_MILLIHZ);

   typedef struct packed
   {
      logic       pin_ctl;
      logic       clk_mclk;
      logic [1:0] hyst;
      logic       rsv;
      logic [2:0] tput;
   } vol_cfg_t;

   typedef struct packed
   {
      logic       rsv;
      logic [6:0] gain;
   } gain_read_t;

   typedef enum logic [1:0]
   {
      SAR_OFF,
      SAR_WAIT,
      SAR_TRIAL
   } sar_state_t;

endpackage : pin_volume_pkg

// ==== pin_volume_props.sv ====
`timescale 1ns/1ps
module pin_volume_props
   import pin_volume_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [6:0]  reg_gain_code,
   input wire logic        sar_power_en,
   input wire logic [6:0]  sar_trial_code,
   input wire logic [6:0]  play_gain_code,
   input wire logic        gain_from_pin
);
   // ===========================================================
   // bus, mode and converter relations
   // ===========================================================
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered in one cycle");
   a_read_upper_zero: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0000_00)
      else $error("read data upper bits not zero");
   a_power_mode: assert property (sar_power_en == gain_from_pin)
      else $error("digitizer power differs from pin mode");
   a_idle_trial: assert property ((!sar_power_en) [*2] |-> sar_trial_code == 7'h00)
      else $error("trial code moves while powered down");
   a_reg_gain: assert property ($past(rst_n) && !gain_from_pin && !$past(gain_from_pin)
      |-> play_gain_code == $past(reg_gain_code))
      else $error("register mode gain not followed");
   a_gain_clamp: assert property (gain_from_pin |-> play_gain_code != GAIN_CODE_RESERVED)
      else $error("reserved gain code applied");
   a_sar_start: assert property (sar_power_en && $past(sar_trial_code) == 7'h00
      && sar_trial_code != 7'h00 |-> sar_trial_code == SAR_FIRST_TRIAL)
      else $error("conversion did not start at half scale");
endmodule : pin_volume_props

bind pin_volume_digitizer_control pin_volume_props u_pin_volume_props (.ref_clk, .rst_n,
   .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .reg_gain_code,
   .sar_power_en, .sar_trial_code, .play_gain_code, .gain_from_pin);

// ==== vol_pin_model.sv ====
`timescale 1ns/1ps
module vol_pin_model
   import pin_volume_pkg::*;
(
   input  wire logic [6:0] sar_trial_code,
   input  wire logic [6:0] pin_level,
   input  wire logic       sar_power_en,
   output logic            volume_detect_above
);
   // a powered-down comparator reads low, so a stray conversion gives code 0
   assign volume_detect_above = sar_power_en && (pin_level >= sar_trial_code);
endmodule : vol_pin_model

// ==== testbench.sv ====
`timescale 1ns/1ps
module testbench
   import pin_volume_pkg::*;
;
   logic        ref_clk, rst_n, avs_read, avs_write, mclk_in, rc_osc_in, run_mclk, run_rc;
   logic [7:0]  avs_address, cfg;
   logic [31:0] avs_writedata, avs_readdata;
   logic        avs_waitrequest, volume_detect_above, sar_power_en, gain_from_pin;
   logic [6:0]  reg_gain_code, lvl, sar_trial_code, play_gain_code;
   logic [16:0] row;
   logic [31:0] exp_q [$];
   int          seed = 32'h1911;
   int          err_count = 0;
   int          check_count = 0;
   // src, hysteresis, pin level, expected applied code
   logic [16:0] tbl [9] = '{{3'h0, 7'h2A, 7'h2A}, {3'h4, 7'h7F, 7'h7E}, {3'h0, 7'h00, 7'h00},
      {3'h6, 7'h30, 7'h30}, {3'h6, 7'h32, 7'h30}, {3'h2, 7'h33, 7'h33},
      {3'h5, 7'h35, 7'h35}, {3'h1, 7'h34, 7'h35}, {3'h4, 7'h34, 7'h34}};

   pin_volume_digitizer_control #(.BASE_DIV(64)) u_pin_volume_digitizer_control (.ref_clk,
      .rst_n, .clk_en(1'b1), .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest, .mclk_in, .rc_osc_in,
      .volume_detect_above, .reg_gain_code, .sar_power_en, .sar_trial_code,
      .play_gain_code, .gain_from_pin);
   vol_pin_model u_vol_pin_model (.sar_trial_code, .pin_level(lvl), .sar_power_en,
      .volume_detect_above);

   // ===========================================================
   // clocks, watcher, tasks
   // ===========================================================
   always #2.5 ref_clk = ~ref_clk;
   // the unselected source stands still, so a wrong clock choice stalls conversions
   always @(posedge ref_clk)
   begin
      if (run_mclk) mclk_in <= ~mclk_in;
      if (run_rc) rc_osc_in <= ~rc_osc_in;
   end

   always @(posedge ref_clk)
      if (avs_read && avs_waitrequest === 1'b0)
         check(avs_readdata, exp_q.pop_front());

   task check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         $display("mismatch %0t seen %h expected %h", $time, seen, exp);
         err_count++;
      end
   endtask : check

   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      avs_address   <= a;
      avs_writedata <= {24'h0000_00, d};
      avs_write     <= w;
      avs_read      <= !w;
      if (!w) exp_q.push_back({24'h0000_00, d});
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task pin_run(input logic [16:0] r);
      run_mclk <= r[16];
      run_rc   <= !r[16];
      lvl     <= r[13:7];
      bus(1'b1, 8'h74, {1'b1, r[16:14], 4'h1});
      // over four and a half conversion periods of 64 cycles at throughput code 1
      repeat (300) @(posedge ref_clk);
      check(play_gain_code, r[6:0]);
      check({30'h0, gain_from_pin, sar_power_en}, 32'h0000_0003);
      bus(1'b0, 8'h75, {1'b0, r[6:0]});
   endtask : pin_run

   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   initial
   begin
      // the whole sequence needs under 4000 cycles; this allows 20000
      #100_000;
      err_count++;
      report_and_stop();
   end

   // ===========================================================
   // main sequence
   // ===========================================================
   initial
   begin
      {ref_clk, rst_n, avs_read, avs_write, mclk_in, rc_osc_in, run_mclk, run_rc} = 8'h00;
      avs_address   = 8'h00;
      avs_writedata = 32'h0000_0000;
      reg_gain_code = 7'h00;
      lvl           = 7'h00;
      repeat (8) @(posedge ref_clk);
      rst_n <= 1'b1;
      bus(1'b0, 8'h00, 8'h00);
      bus(1'b0, 8'h74, 8'h00);
      bus(1'b0, 8'h75, 8'h00);
      $display("test reset done");
      repeat (4)
      begin
         cfg = 8'($random(seed)) & 8'h57;
         reg_gain_code <= 7'($random(seed));
         bus(1'b1, 8'h74, cfg);
         bus(1'b0, 8'h74, cfg);
      end
      bus(1'b1, 8'h10, 8'h5A);
      foreach (tbl[i])
         if (i < 5) bus(1'b0, i == 0 ? 8'h10 : (i < 3 ? 8'h4E + 8'(i * 2) : 8'h74 + 8'(i)), 8'h00);
      bus(1'b0, 8'h7F, 8'h00);
      $display("test map done");
      bus(1'b1, 8'h00, 8'hFF);
      bus(1'b0, 8'h00, 8'hFF);
      bus(1'b0, 8'h74, 8'h00);
      bus(1'b1, 8'h00, 8'h00);
      bus(1'b0, 8'h74, cfg);
      $display("test page done");
      foreach (tbl[i])
         pin_run(tbl[i]);
      row = {3'h0, 7'h00, 7'h00};
      row[13:7] = 7'h40 + 7'({$random(seed)} % 60);
      row[6:0] = row[13:7];
      pin_run(row);
      $display("test pin done");
      bus(1'b1, 8'h74, 8'h00);
      reg_gain_code <= 7'($random(seed));
      repeat (3) @(posedge ref_clk);
      check({25'h0, play_gain_code}, {25'h0, reg_gain_code});
      check({30'h0, gain_from_pin, sar_power_en}, 32'h0000_0000);
      $display("test register mode done");
      report_and_stop();
   end
endmodule : testbench
